// *** plc_pkg.sv ***
// Package for the position latch capture block
package plc_pkg;
    // Axis count and widths
    localparam int              PLC_AXES        = 4;
    localparam int              PLC_POS_W       = 32;
    localparam int              PLC_WORD_W      = 16;
    localparam int              PLC_ADDR_W      = 11;
    // Operand table limits and codes
    localparam logic [15:0]     PLC_FUNC_CAPTURE = 16'h0004;
    localparam logic [15:0]     PLC_SRC_GPIN     = 16'h0001;
    localparam logic [15:0]     PLC_SRC_INDEX    = 16'h0002;
    localparam logic [15:0]     PLC_SLOT_MAX     = 16'h07CF;
    localparam logic [15:0]     PLC_TABLE_MAX    = 16'h07CC;
    localparam logic [15:0]     PLC_STAT_WAIT    = 16'h0000;
    localparam logic [15:0]     PLC_STAT_DONE    = 16'h0001;
    // Register bus offsets
    localparam logic [3:0]      PLC_OFF_CMD      = 4'h0;
    localparam logic [3:0]      PLC_OFF_TPTR     = 4'h1;
    localparam logic [3:0]      PLC_OFF_FUNC     = 4'h2;
    localparam logic [3:0]      PLC_OFF_SRC      = 4'h3;
    localparam logic [3:0]      PLC_OFF_SLOT     = 4'h4;
    localparam logic [3:0]      PLC_OFF_STAT     = 4'h5;
    localparam logic [3:0]      PLC_OFF_ERR      = 4'h6;
    localparam logic [3:0]      PLC_OFF_RDSLOT   = 4'h7;
    localparam logic [3:0]      PLC_OFF_RDPOS    = 4'h8;
    localparam logic [3:0]      PLC_OFF_ARMED    = 4'h9;
    // Command word fields
    localparam int              PLC_CMD_AXIS_LSB = 0;
    localparam int              PLC_CMD_TBL_BIT  = 2;
    localparam int              PLC_CMD_END_BIT  = 3;
    localparam int              PLC_CMD_RST_BIT  = 4;
    // Reset values
    localparam logic [15:0]     PLC_RST_WORD     = 16'h0000;

    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } plc_bus_type;

    // Trigger inputs per axis
    typedef struct packed {
        logic [3:0] gpin;
        logic [3:0] index;
    } plc_trig_type;
endpackage

// *** plc_capture.sv ***
// Position latch capture block: arming, triggers, slot store, status
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
// Functional notes
// R01 - Rising edge of selected trigger stores the axis position in the chosen slot.
// R02 - Source word 1 selects general input edge, 2 selects index edge.
// R03 - Index uses the latched axis; general input n serves axis n.
// R04 - Slot index must be 0 to 1999, else range error.
// R05 - Status reads 0 on command, 1 when the capture happens.
// R06 - Function word must be 4; above 4 raises range error.
// R07 - Table start index above 1996 is rejected with range error.
// R08 - All table settings range checked except the status word.
// R09 - Command only arms; sequencer proceeds at once.
// R10 - Armed capture fires even while program execution is halted.
// R11 - Disarm on capture, program end completion, or program restart.
// R12 - New command for same axis and source replaces the old one.
// R13 - Program must not share the trigger input with other consumers.
// R14 - Host must enable customized function bit 04 first.
// R15 - Non table pointer move form runs as ordinary linear move.
// R16 - Tasks must interlock use of the shared table pointer register.
// R17 - Triggers synchronised to clock, edge found from two samples.
module plc_capture #(
    parameter int POS_W = plc_pkg::PLC_POS_W
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // Register bus
    input  wire plc_pkg::plc_bus_type  i_bus,
    output logic [31:0]                o_rdata,
    // Trigger inputs and encoder positions
    input  wire plc_pkg::plc_trig_type i_trig,
    input  wire logic [4*POS_W-1:0]    i_pos,
    // Program state
    input  wire logic                  i_halted,
    // Results
    output logic                       o_advance,
    output logic                       o_linear_move,
    output logic                       o_range_err,
    output logic [3:0]                 o_armed
);
    import plc_pkg::*;

    typedef enum logic [1:0] {
        PLC_IDLE  = 2'b00,
        PLC_ARMED = 2'b01,
        PLC_DONE  = 2'b11
    } plc_state_type;

    ////////////////////////////////////////////////////////////////////
    // Range check helper, used per field
    function automatic logic plc_over(input logic [15:0] v, input logic [15:0] lim);
        plc_over = (v > lim);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Software registers
    logic [15:0]        tptr_r;
    logic [15:0]        func_r;
    logic [15:0]        src_r;
    logic [15:0]        slot_r;
    logic [15:0]        stat_r;
    logic [15:0]        rdslot_r;
    logic               err_r;
    logic               cmd_go;
    logic [1:0]         cmd_axis;
    logic               cmd_tbl;
    logic               cmd_end;
    logic               cmd_rst;
    logic               cmd_bad;

    assign cmd_go   = i_bus.wr && (i_bus.addr == PLC_OFF_CMD);
    assign cmd_axis = i_bus.wdata[PLC_CMD_AXIS_LSB +: 2];
    assign cmd_tbl  = i_bus.wdata[PLC_CMD_TBL_BIT];
    assign cmd_end  = cmd_go && i_bus.wdata[PLC_CMD_END_BIT];
    assign cmd_rst  = cmd_go && i_bus.wdata[PLC_CMD_RST_BIT];
    // Operand range checks, status not checked
    assign cmd_bad  = plc_over(tptr_r, PLC_TABLE_MAX)                         // [R07]
                   || plc_over(func_r, PLC_FUNC_CAPTURE)                       // [R06]
                   || (func_r != PLC_FUNC_CAPTURE)                             // [R08]
                   || ((src_r != PLC_SRC_GPIN) && (src_r != PLC_SRC_INDEX))    // [R02]
                   || plc_over(slot_r, PLC_SLOT_MAX);                          // [R04]

    logic cap_cmd;
    assign cap_cmd = cmd_go && cmd_tbl && !cmd_end && !cmd_rst && !cmd_bad;

    // Operand table words
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tptr_r   <= PLC_RST_WORD;
            func_r   <= PLC_RST_WORD;
            src_r    <= PLC_RST_WORD;
            slot_r   <= PLC_RST_WORD;
            rdslot_r <= PLC_RST_WORD;
        end else if (i_bus.wr) begin
            if (i_bus.addr == PLC_OFF_TPTR) begin
                tptr_r <= i_bus.wdata[15:0];
            end else if (i_bus.addr == PLC_OFF_FUNC) begin
                func_r <= i_bus.wdata[15:0];
            end else if (i_bus.addr == PLC_OFF_SRC) begin
                src_r <= i_bus.wdata[15:0];
            end else if (i_bus.addr == PLC_OFF_SLOT) begin
                slot_r <= i_bus.wdata[15:0];
            end else if (i_bus.addr == PLC_OFF_RDSLOT) begin
                rdslot_r <= i_bus.wdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trigger synchronisers and edge detect
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] prev_r;
    logic [7:0] rise;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            prev_r  <= 8'h00;
        end else begin
            sync1_r <= {i_trig.index, i_trig.gpin};                         // [R17]
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end
    assign rise = sync2_r & ~prev_r;                                        // [R17]

    ////////////////////////////////////////////////////////////////////
    // Per axis arming state
    plc_state_type      st_r [4];
    logic               sel_idx_r [4];
    logic [10:0]        dst_r [4];
    logic [3:0]         fire;
    logic [3:0]         take;
    logic [3:0]         armed_v;

    for (genvar a = 0; a < 4; a++) begin : g_axis
        // Index of this axis or general input a
        assign fire[a] = (st_r[a] == PLC_ARMED)
                      && (sel_idx_r[a] ? rise[4+a] : rise[a]);              // [R03]
        assign armed_v[a] = (st_r[a] == PLC_ARMED);
        // Edge dropped in a cycle that disarms or re-arms this axis
        assign take[a] = fire[a] && !(cmd_end || cmd_rst)
                      && !(cap_cmd && (cmd_axis == 2'(a)));                 // [R12]
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                st_r[a]      <= PLC_IDLE;
                sel_idx_r[a] <= 1'b0;
                dst_r[a]     <= 11'h000;
            end else if (cmd_end || cmd_rst) begin
                st_r[a] <= PLC_IDLE;                                        // [R11]
            end else if (cap_cmd && (cmd_axis == 2'(a))) begin
                st_r[a]      <= PLC_ARMED;                                  // [R09] [R12]
                sel_idx_r[a] <= (src_r == PLC_SRC_INDEX);                   // [R02]
                dst_r[a]     <= slot_r[10:0];
            end else if (fire[a]) begin
                st_r[a] <= PLC_DONE;                                        // [R10] [R11]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Position data slots
    logic [POS_W-1:0]   slots [2000];
    logic [POS_W-1:0]   rdpos_r;
    logic [1999:0]      slot_vld_r;

    // Capture store, lowest axis wins if two hit one slot
    always_ff @(posedge i_clk) begin
        for (int a = 3; a >= 0; a--) begin
            if (take[a]) begin
                slots[dst_r[a]] <= i_pos[a*POS_W +: POS_W];                 // [R01]
            end
        end
    end

    // Written flags, so an unused slot reads back as zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slot_vld_r <= '0;
        end else begin
            for (int a = 0; a < 4; a++) begin
                if (take[a]) begin
                    slot_vld_r[dst_r[a]] <= 1'b1;                           // [R01]
                end
            end
        end
    end

    // Slot readback
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdpos_r <= '0;
        end else if (!plc_over(rdslot_r, PLC_SLOT_MAX) && slot_vld_r[rdslot_r[10:0]]) begin
            rdpos_r <= slots[rdslot_r[10:0]];
        end else begin
            rdpos_r <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status word, error flag and sequencer outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_r <= PLC_STAT_WAIT;
        end else if (|take) begin
            stat_r <= PLC_STAT_DONE;                                        // [R05]
        end else if (cap_cmd) begin
            stat_r <= PLC_STAT_WAIT;                                        // [R05]
        end else if (i_bus.wr && (i_bus.addr == PLC_OFF_STAT)) begin
            stat_r <= i_bus.wdata[15:0];                                    // [R08]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_r         <= 1'b0;
            o_advance     <= 1'b0;
            o_linear_move <= 1'b0;
            o_armed       <= 4'h0;
        end else begin
            if (cmd_go && cmd_tbl && !cmd_end && !cmd_rst && cmd_bad) begin
                err_r <= 1'b1;                                              // [R04] [R06] [R07]
            end else if (i_bus.wr && (i_bus.addr == PLC_OFF_ERR)) begin
                err_r <= 1'b0;
            end
            o_advance     <= cmd_go && !cmd_end && !cmd_rst;                // [R09]
            o_linear_move <= cmd_go && !cmd_tbl && !cmd_end && !cmd_rst;    // [R15]
            o_armed       <= armed_v;
        end
    end
    assign o_range_err = err_r;

    ////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_bus.rd) begin
            if (i_bus.addr == PLC_OFF_TPTR) begin
                o_rdata <= {16'h0000, tptr_r};
            end else if (i_bus.addr == PLC_OFF_FUNC) begin
                o_rdata <= {16'h0000, func_r};
            end else if (i_bus.addr == PLC_OFF_SRC) begin
                o_rdata <= {16'h0000, src_r};
            end else if (i_bus.addr == PLC_OFF_SLOT) begin
                o_rdata <= {16'h0000, slot_r};
            end else if (i_bus.addr == PLC_OFF_STAT) begin
                o_rdata <= {16'h0000, stat_r};
            end else if (i_bus.addr == PLC_OFF_ERR) begin
                o_rdata <= {31'h00000000, err_r};
            end else if (i_bus.addr == PLC_OFF_RDSLOT) begin
                o_rdata <= {16'h0000, rdslot_r};
            end else if (i_bus.addr == PLC_OFF_RDPOS) begin
                o_rdata <= 32'(rdpos_r);
            end else if (i_bus.addr == PLC_OFF_ARMED) begin
                o_rdata <= {28'h0000000, armed_v};
            end else begin
                o_rdata <= 32'h00000000;
            end
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_edge_fires;
        (st_r[0] == PLC_ARMED) && !sel_idx_r[0] && sync2_r[0] && !prev_r[0]
            && !cmd_go |=> stat_r == PLC_STAT_DONE;
    endproperty
    a_edge_fires: assert property (p_edge_fires) // [R01]
        else $error("Edge did not complete capture");

    property p_index_sel;
        cap_cmd && (cmd_axis == 2'd1) && (src_r == PLC_SRC_INDEX) |=> sel_idx_r[1];
    endproperty
    a_index_sel: assert property (p_index_sel) else $error("Index source not selected"); // [R02]

    property p_gpin_ignored;
        (st_r[2] == PLC_ARMED) && sel_idx_r[2] && !rise[6] && !cmd_go |=> st_r[2] == PLC_ARMED;
    endproperty
    a_gpin_ignored: assert property (p_gpin_ignored) // [R03]
        else $error("Wrong input fired capture");

    property p_slot_err;
        cmd_go && cmd_tbl && !cmd_end && !cmd_rst && (slot_r > PLC_SLOT_MAX) |=> err_r;
    endproperty
    a_slot_err: assert property (p_slot_err) else $error("Slot range error missing"); // [R04]

    property p_wait_stat;
        cap_cmd && !(|fire) |=> (stat_r == PLC_STAT_WAIT) ##1 o_armed != 4'h0;
    endproperty
    a_wait_stat: assert property (p_wait_stat) // [R05]
        else $error("Status not waiting after arm");

    property p_func_err;
        cmd_go && cmd_tbl && !cmd_end && !cmd_rst && (func_r > PLC_FUNC_CAPTURE) |=> err_r;
    endproperty
    a_func_err: assert property (p_func_err) else $error("Function code error missing"); // [R06]

    property p_tbl_err;
        cmd_go && cmd_tbl && !cmd_end && !cmd_rst && (tptr_r > PLC_TABLE_MAX) && !fire[0]
            |=> err_r && $stable(st_r[0]);
    endproperty
    a_tbl_err: assert property (p_tbl_err) else $error("Table pointer error missing"); // [R07]

    property p_advance;
        cap_cmd |=> o_advance;
    endproperty
    a_advance: assert property (p_advance) else $error("Sequencer not advanced"); // [R09]

    property p_disarm;
        cmd_rst |=> armed_v == 4'h0 ##1 o_armed == 4'h0;
    endproperty
    a_disarm: assert property (p_disarm) else $error("Restart did not disarm"); // [R11]

    property p_linear;
        cmd_go && !cmd_tbl && !cmd_end && !cmd_rst && !(|fire)
            |=> o_linear_move && !$changed(stat_r);
    endproperty
    a_linear: assert property (p_linear) else $error("Linear move not issued"); // [R15]

    c_arm:    cover property (cap_cmd);
    c_fire:   cover property (|fire);
    c_halted: cover property (i_halted && (|fire));
    c_err:    cover property ($rose(err_r));
endmodule // plc_capture

// *** plc_motion_model.sv ***
// Encoder and trigger line model standing in for the interpreter side
`timescale 1ns/10ps
module plc_motion_model (
    // Clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_rst_n,
    // Requests from the bench
    input  wire logic [4*plc_pkg::PLC_POS_W-1:0] i_new_pos,
    input  wire logic [3:0]                      i_gp_req,
    input  wire logic [3:0]                      i_ix_req,
    // Lines into the capture block
    output plc_pkg::plc_trig_type                o_trig,
    output logic [4*plc_pkg::PLC_POS_W-1:0]      o_pos
);
    import plc_pkg::*;
    logic [3:0] gp_a_r;
    logic [3:0] gp_b_r;
    logic [3:0] ix_a_r;
    logic [3:0] ix_b_r;
    ////////////////////////////////////////////////////////////////////
    // Two-cycle pulses, idle low; one consumer per line
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gp_a_r <= 4'h0;
            gp_b_r <= 4'h0;
            ix_a_r <= 4'h0;
            ix_b_r <= 4'h0;
        end else begin
            gp_a_r <= i_gp_req;
            gp_b_r <= gp_a_r;
            ix_a_r <= i_ix_req;
            ix_b_r <= ix_a_r;
        end
    end
    assign o_trig = '{gpin: gp_a_r | gp_b_r, index: ix_a_r | ix_b_r};
    // Encoder counts, held steady around each trigger
    always_ff @(posedge i_clk) begin
        o_pos <= i_new_pos;
    end
    // Capture feature assumed enabled, single task owns the pointer
endmodule // plc_motion_model

// *** testbench.sv ***
// Self-checking bench for the position latch capture block
`timescale 1ns/10ps
module testbench;
    import plc_pkg::*;
    logic i_clk, i_rst_n, halted, rd_d;
    plc_bus_type bus;
    plc_trig_type trig;
    logic [127:0] pos_new, pos;
    logic [31:0] o_rdata, pv;
    integer seed;
    logic [3:0] gp, ix, o_armed;
    logic o_advance, o_linear_move, o_range_err;
    int failures, checks, adv_cnt, lin_cnt, adv_exp, cyc;
    logic [31:0] q[$];
    logic [15:0] bad [5][4] = '{'{1997, 4, 1, 0}, '{0, 5, 1, 0}, '{0, 4, 0, 0},
                                '{0, 4, 3, 0}, '{0, 4, 1, 2000}};
    plc_capture u_plc_capture (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus),
        .o_rdata(o_rdata), .i_trig(trig), .i_pos(pos), .i_halted(halted),
        .o_advance(o_advance), .o_linear_move(o_linear_move),
        .o_range_err(o_range_err), .o_armed(o_armed));
    plc_motion_model u_plc_motion_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_new_pos(pos_new), .i_gp_req(gp), .i_ix_req(ix), .o_trig(trig), .o_pos(pos));
    ////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Bus cycles, each strobe one clock long
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge i_clk) bus <= {2'b10, ad, d};
        @(posedge i_clk) bus <= '0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [31:0] e);
        q.push_back(e);
        @(posedge i_clk) bus <= {2'b01, ad, 32'h0};
        @(posedge i_clk) bus <= '0;
    endtask
    task automatic cap(input int a, input int tp, input int fn, input int src,
                       input int slt);
        wr(PLC_OFF_TPTR, tp);
        wr(PLC_OFF_FUNC, fn);
        wr(PLC_OFF_SRC, src);
        wr(PLC_OFF_SLOT, slt);
        wr(PLC_OFF_CMD, 32'h4 | a);
        adv_exp++;
    endtask
    task automatic pulse(input logic [3:0] g, input logic [3:0] x);
        @(posedge i_clk) begin
            gp <= g;
            ix <= x;
        end
        @(posedge i_clk) begin
            gp <= 4'h0;
            ix <= 4'h0;
        end
        repeat (8) @(posedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end
    // Read data checked in the cycle after each read strobe
    always @(posedge i_clk) begin
        if (rd_d === 1'b1) check(o_rdata, q.pop_front());
        if (o_advance === 1'b1) adv_cnt++;
        if (o_linear_move === 1'b1) lin_cnt++;
        rd_d <= bus.rd;
    end
    // Main sequence
    initial begin
        seed = 32'hBC846DD6;
        {i_rst_n, halted, rd_d, gp, ix, pos_new} = '0;
        bus = '0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(PLC_OFF_STAT, 0);
        rd(PLC_OFF_ERR, 0);
        rd(PLC_OFF_ARMED, 0);
        rd(4'hF, 0);
        rd(PLC_OFF_RDPOS, 0);
        $display("test reset done");
        for (int s = 1; s <= 2; s++) begin
            for (int a = 0; a < 4; a++) begin
                pv = $random(seed);
                pos_new[a*32+:32] <= pv;
                halted <= a[0];
                cap(a, (a == 1) ? 1996 : 1000, 4, s, a * 666 + s - 1);
                rd(PLC_OFF_STAT, 0);
                rd(PLC_OFF_ARMED, 1 << a);
                check({28'h0, o_armed}, 1 << a);
                if (s == 1) pulse(4'h1 << ((a + 1) % 4), 4'h1 << a);
                else pulse(4'h1 << a, 4'h1 << ((a + 1) % 4));
                rd(PLC_OFF_STAT, 0);
                if (s == 1) pulse(4'h1 << a, 4'h0);
                else pulse(4'h0, 4'h1 << a);
                rd(PLC_OFF_STAT, 1);
                rd(PLC_OFF_ARMED, 0);
                wr(PLC_OFF_RDSLOT, a * 666 + s - 1);
                rd(PLC_OFF_RDPOS, pv);
            end
        end
        $display("test capture done");
        for (int i = 0; i < 5; i++) begin
            wr(PLC_OFF_ERR, 0);
            cap(0, bad[i][0], bad[i][1], bad[i][2], bad[i][3]);
            rd(PLC_OFF_ERR, 1);
            rd(PLC_OFF_ARMED, 0);
            check({31'h0, o_range_err}, 1);
        end
        wr(PLC_OFF_ERR, 0);
        wr(PLC_OFF_STAT, 7);
        rd(PLC_OFF_STAT, 7);
        rd(PLC_OFF_ERR, 0);
        wr(PLC_OFF_CMD, 0);
        adv_exp++;
        rd(PLC_OFF_ARMED, 0);
        $display("test errors done");
        for (int k = 8; k <= 16; k += 8) begin
            cap(2, 0, 4, 1, 5);
            rd(PLC_OFF_ARMED, 4);
            wr(PLC_OFF_CMD, k);
            rd(PLC_OFF_ARMED, 0);
            check({28'h0, o_armed}, 0);
            pulse(4'h4, 4'h0);
            rd(PLC_OFF_STAT, 0);
        end
        $display("test disarm done");
        pv = $random(seed);
        pos_new[32+:32] <= pv;
        cap(1, 0, 4, 1, 10);
        cap(1, 0, 4, 2, 11);
        rd(PLC_OFF_ARMED, 2);
        pulse(4'h2, 4'h0);
        rd(PLC_OFF_STAT, 0);
        pulse(4'h0, 4'h2);
        rd(PLC_OFF_STAT, 1);
        wr(PLC_OFF_RDSLOT, 11);
        rd(PLC_OFF_RDPOS, pv);
        wr(PLC_OFF_RDSLOT, 10);
        rd(PLC_OFF_RDPOS, 0);
        $display("test replace done");
        repeat (4) @(posedge i_clk);
        check(adv_cnt, adv_exp);
        check(lin_cnt, 1);
        finish_test();
    end
endmodule // testbench
